// >>> hdl/ists_pkg.sv
// shared constants and types of the i2c target transmit / stretch block
package ists_pkg;
    // ----------------------------------------------------------------
    // widths and bit counts
    // ----------------------------------------------------------------
    localparam int         BYTE_W    = 8;
    localparam logic [3:0] BIT_LAST  = 4'h8;
    localparam logic [3:0] BIT_ACK   = 4'h9;
    localparam logic [3:0] CNT_RST   = 4'h0;
    // ----------------------------------------------------------------
    // address layout
    // ----------------------------------------------------------------
    localparam logic [4:0] TEN_PFX   = 5'h1E;
    localparam int         HI_MSB    = 2;
    localparam int         HI_LSB    = 1;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic       CKP_RST   = 1'b1;
    localparam logic [7:0] ADDR_RST  = 8'h00;
    localparam logic [7:0] BYTE_RST  = 8'h00;
    // ----------------------------------------------------------------
    // bus sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_RX,
        ST_TX
    } ists_state_t;
endpackage

// >>> hdl/ists_core.sv
// i2c target: read-data transmit, 10-bit addressing and clock stretching
//
// Functional notes
// [RULE_01] collision while sending with detect enabled: flag it, drop transfer, go idle.
// [RULE_02] start condition sets start seen bit, and interrupt flag when enabled.
// [RULE_03] matching read address: acknowledge, interrupt, clear clock release after ack.
// [RULE_04] setting clock release lets scl go so the byte is clocked out.
// [RULE_05] controller acknowledge captured on rising scl of ninth pulse.
// [RULE_06] during reads, interrupt once controller acknowledge is stored.
// [RULE_07] controller nack: no stretch, still interrupt, release bus for stop.
// [RULE_08] after each acknowledged read byte clear clock release, whatever buffer full says.
// [RULE_09] address hold: at eighth fall of match clear release, stretch, interrupt.
// [RULE_10] under a hold option ack value comes from software, sent after release.
// [RULE_11] address hold with read: again clear release and interrupt after ack.
// [RULE_12] controller must nack the final read byte so scl is released.
// [RULE_13] 10-bit high byte write match: ack, set update flag and interrupt.
// [RULE_14] update flag stretches scl without clearing release; address write frees it.
// [RULE_15] software rewrites the address only after the ack sequence ends.
// [RULE_16] low byte mismatch still sets interrupt and update flag; no buffer full.
// [RULE_17] buffer read clears buffer full; buffer load sets it.
// [RULE_18] stretch enable: after each received byte and ack clear release, hold scl.
// [RULE_19] cleared release holds scl only once it is already low.
// [RULE_20] data hold: clear release at eighth fall of each received data byte.
// [RULE_21] 10-bit mode holds and interrupts at the same points as 7-bit.
// [RULE_22] repeated start or stop leaves the target unaddressed.
// [RULE_23] 10-bit first byte compared with 11110, two upper address bits, zero.
// [RULE_24] transmit data changes on falling scl, stable while scl high.
// [RULE_25] scl and sda only pulled low or released, never driven high.
`timescale 1ns/1ps
module ists_core (
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       ten_bit_mode_i,
    input  wire logic       start_irq_enable_i,
    input  wire logic       collision_detect_enable_i,
    input  wire logic       address_hold_enable_i,
    input  wire logic       data_hold_enable_i,
    input  wire logic       stretch_enable_i,
    input  wire logic       ack_value_bit_i,
    input  wire logic       clock_hold_release_set_i,
    input  wire logic       irq_clear_i,
    input  wire logic       collision_clear_i,
    input  wire logic       address_write_i,
    input  wire logic [7:0] address_wdata_i,
    input  wire logic       buffer_write_i,
    input  wire logic [7:0] buffer_wdata_i,
    input  wire logic       buffer_read_i,
    output logic [7:0]      rx_tx_buffer_o,
    output logic [7:0]      slave_address_o,
    output logic            buffer_full_flag_o,
    output logic            clock_hold_release_o,
    output logic            serial_port_irq_flag_o,
    output logic            bus_collision_flag_o,
    output logic            start_seen_bit_o,
    output logic            ack_status_bit_o,
    output logic            ack_timing_bit_o,
    output logic            address_update_flag_o,
    output logic            read_write_o
);
    // ----------------------------------------------------------------
    // pin synchronisers and bus condition detect
    // ----------------------------------------------------------------
    logic scl_m_reg, scl_s_reg, scl_d_reg;
    logic sda_m_reg, sda_s_reg, sda_d_reg;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            scl_m_reg <= 1'b1;
            scl_s_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_m_reg <= 1'b1;
            sda_s_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_m_reg <= scl_i;
            scl_s_reg <= scl_m_reg;
            scl_d_reg <= scl_s_reg;
            sda_m_reg <= sda_i;
            sda_s_reg <= sda_m_reg;
            sda_d_reg <= sda_s_reg;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise  = scl_s_reg & ~scl_d_reg;
    assign scl_fall  = ~scl_s_reg & scl_d_reg;
    assign start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
    assign stop_det  = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    ists_pkg::ists_state_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next, buf_reg, buf_next, sa_reg, sa_next;
    logic sda_oe_reg, sda_oe_next, scl_oe_reg, scl_oe_next;
    logic hold_reg, hold_next, nack_reg, nack_next, match_reg, match_next;
    logic rw_reg, rw_next, lo_reg, lo_next, ten_ok_reg, ten_ok_next;
    logic ack_timing_bit_reg, ack_timing_bit_next, ackst_reg, ackst_next, ss_reg, ss_next;
    logic irq_reg, irq_next, bf_reg, bf_next, ua_reg, ua_next;
    logic bcl_reg, bcl_next, ckp_reg, ckp_next;
    logic ckp_clr, irq_set, ua_set, bf_set, bf_clr_hw, bcl_set, m, coll;
    logic [7:0] hi_pat;

    always_comb begin
        st_next     = st_reg;
        cnt_next    = cnt_reg;
        shift_next  = shift_reg;
        buf_next    = buf_reg;
        sda_oe_next = sda_oe_reg;
        hold_next   = hold_reg;
        nack_next   = nack_reg;
        match_next  = match_reg;
        rw_next     = rw_reg;
        lo_next     = lo_reg;
        ten_ok_next = ten_ok_reg;
        ack_timing_bit_next = ack_timing_bit_reg;
        ackst_next  = ackst_reg;
        ss_next     = ss_reg;
        ckp_clr     = 1'b0;
        irq_set     = 1'b0;
        ua_set      = 1'b0;
        bf_set      = 1'b0;
        bf_clr_hw   = 1'b0;
        bcl_set     = 1'b0;
        m           = 1'b0;
        coll        = 1'b0;
        hi_pat = {ists_pkg::TEN_PFX, sa_reg[ists_pkg::HI_MSB:ists_pkg::HI_LSB], 1'b0}; // RULE_23
        // software load; in transmit at bit count zero it also primes the shifter and first bit
        if (buffer_write_i) begin
            buf_next = buffer_wdata_i;
            bf_set   = 1'b1; // RULE_17
            if (st_reg == ists_pkg::ST_TX && cnt_reg == ists_pkg::CNT_RST) begin
                shift_next  = buffer_wdata_i;
                sda_oe_next = ~buffer_wdata_i[7];
            end
        end
        if (start_det) begin
            st_next     = ists_pkg::ST_ADDR; // RULE_22
            cnt_next    = ists_pkg::CNT_RST;
            sda_oe_next = 1'b0;
            hold_next   = 1'b0;
            lo_next     = 1'b0;
            ack_timing_bit_next = 1'b0;
            ss_next     = 1'b1; // RULE_02
            irq_set     = start_irq_enable_i; // RULE_02
        end else if (stop_det) begin
            st_next     = ists_pkg::ST_IDLE; // RULE_22
            sda_oe_next = 1'b0;
            hold_next   = 1'b0;
            lo_next     = 1'b0;
            ten_ok_next = 1'b0;
            ack_timing_bit_next = 1'b0;
            ss_next     = 1'b0;
        end else if (st_reg != ists_pkg::ST_IDLE) begin
            if (scl_rise) begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg < ists_pkg::BIT_LAST) begin
                    if (st_reg != ists_pkg::ST_TX) begin
                        shift_next = {shift_reg[6:0], sda_s_reg};
                    end else if (!sda_oe_reg && !sda_s_reg) begin
                        coll = collision_detect_enable_i;
                    end
                end else if (st_reg == ists_pkg::ST_TX) begin
                    ackst_next = sda_s_reg; // RULE_05
                end
            end
            if (coll) begin
                bcl_set     = 1'b1; // RULE_01
                st_next     = ists_pkg::ST_IDLE; // RULE_01
                sda_oe_next = 1'b0;
            end else if (scl_fall && cnt_reg == ists_pkg::BIT_LAST) begin
                unique case (st_reg)
                    ists_pkg::ST_ADDR: begin
                        if (!ten_bit_mode_i) begin
                            m = shift_reg[7:1] == sa_reg[7:1];
                        end else if (lo_reg) begin
                            m = shift_reg == sa_reg;
                        end else begin
                            m = shift_reg[7:1] == hi_pat[7:1] && (!shift_reg[0] || ten_ok_reg);
                        end
                        match_next = m;
                        nack_next  = ~m;
                        if (m) begin
                            buf_next = shift_reg;
                            bf_set   = 1'b1; // RULE_16
                            if (!lo_reg) begin
                                rw_next = shift_reg[0];
                            end
                        end
                        if (m && address_hold_enable_i) begin
                            ckp_clr     = 1'b1; // RULE_09 RULE_21
                            irq_set     = 1'b1; // RULE_09
                            ack_timing_bit_next = 1'b1;
                            hold_next   = 1'b1;
                        end else if (m) begin
                            sda_oe_next = 1'b1; // RULE_03 RULE_13
                        end else if (!lo_reg) begin
                            st_next = ists_pkg::ST_IDLE;
                        end
                    end
                    ists_pkg::ST_RX: begin
                        buf_next  = shift_reg;
                        bf_set    = 1'b1;
                        nack_next = 1'b0;
                        if (data_hold_enable_i) begin
                            ckp_clr     = 1'b1; // RULE_20
                            irq_set     = 1'b1;
                            ack_timing_bit_next = 1'b1;
                            hold_next   = 1'b1;
                        end else begin
                            sda_oe_next = 1'b1;
                        end
                    end
                    ists_pkg::ST_TX: begin
                        sda_oe_next = 1'b0;
                        bf_clr_hw   = 1'b1;
                    end
                    ists_pkg::ST_IDLE: ;
                endcase
            end else if (scl_fall && cnt_reg == ists_pkg::BIT_ACK) begin
                cnt_next    = ists_pkg::CNT_RST;
                sda_oe_next = 1'b0;
                ack_timing_bit_next = 1'b0;
                hold_next   = 1'b0;
                unique case (st_reg)
                    ists_pkg::ST_ADDR: begin
                        if (lo_reg) begin
                            ua_set  = 1'b1; // RULE_16
                            irq_set = 1'b1; // RULE_16
                            lo_next = 1'b0;
                            if (match_reg && !nack_reg) begin
                                ten_ok_next = 1'b1;
                                st_next     = ists_pkg::ST_RX;
                            end else begin
                                st_next = ists_pkg::ST_IDLE;
                            end
                        end else if (nack_reg) begin
                            st_next = ists_pkg::ST_IDLE;
                        end else begin
                            irq_set = 1'b1; // RULE_03 RULE_11 RULE_13
                            if (rw_reg) begin
                                ckp_clr = 1'b1; // RULE_03 RULE_11
                                st_next = ists_pkg::ST_TX;
                            end else if (ten_bit_mode_i) begin
                                ua_set  = 1'b1; // RULE_13
                                lo_next = 1'b1;
                            end else begin
                                st_next = ists_pkg::ST_RX;
                                ckp_clr = stretch_enable_i;
                            end
                        end
                    end
                    ists_pkg::ST_RX: begin
                        if (nack_reg) begin
                            st_next = ists_pkg::ST_IDLE;
                        end else begin
                            irq_set = 1'b1;
                            ckp_clr = stretch_enable_i; // RULE_18
                        end
                    end
                    ists_pkg::ST_TX: begin
                        irq_set = 1'b1; // RULE_06 RULE_07
                        if (ackst_reg) begin
                            st_next = ists_pkg::ST_IDLE; // RULE_07 RULE_12
                        end else begin
                            ckp_clr = 1'b1; // RULE_08
                        end
                    end
                    ists_pkg::ST_IDLE: ;
                endcase
            end else if (scl_fall && st_reg == ists_pkg::ST_TX && cnt_reg != ists_pkg::CNT_RST) begin
                shift_next  = {shift_reg[6:0], 1'b0};
                sda_oe_next = ~shift_reg[6]; // RULE_24
            end
            // held acknowledge goes out only once software releases the clock
            if (hold_reg && clock_hold_release_set_i && !ckp_clr) begin
                hold_next   = 1'b0;
                sda_oe_next = ~ack_value_bit_i; // RULE_10
                nack_next   = ack_value_bit_i;
            end
        end
    end

    // ----------------------------------------------------------------
    // flags and clock stretch; hardware set beats a same-cycle clear
    // ----------------------------------------------------------------
    always_comb begin
        irq_next = irq_set | (irq_reg & ~irq_clear_i);
        bf_next  = bf_set | (bf_reg & ~buffer_read_i & ~bf_clr_hw); // RULE_17
        ua_next  = ua_set | (ua_reg & ~address_write_i); // RULE_14
        bcl_next = bcl_set | (bcl_reg & ~collision_clear_i);
        sa_next  = address_write_i ? address_wdata_i : sa_reg;
        // hardware clear wins so a stretch point is never skipped
        ckp_next = ~ckp_clr & (ckp_reg | clock_hold_release_set_i); // RULE_04
        // never pull scl down in mid high time: wait for it to be low first
        scl_oe_next = (~ckp_reg | ua_reg) & (scl_oe_reg | ~scl_s_reg); // RULE_19 RULE_14
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg     <= ists_pkg::ST_IDLE;
            cnt_reg    <= ists_pkg::CNT_RST;
            shift_reg  <= ists_pkg::BYTE_RST;
            buf_reg    <= ists_pkg::BYTE_RST;
            sa_reg     <= ists_pkg::ADDR_RST;
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            hold_reg   <= 1'b0;
            nack_reg   <= 1'b0;
            match_reg  <= 1'b0;
            rw_reg     <= 1'b0;
            lo_reg     <= 1'b0;
            ten_ok_reg <= 1'b0;
            ack_timing_bit_reg <= 1'b0;
            ackst_reg  <= 1'b0;
            ss_reg     <= 1'b0;
            irq_reg    <= 1'b0;
            bf_reg     <= 1'b0;
            ua_reg     <= 1'b0;
            bcl_reg    <= 1'b0;
            ckp_reg    <= ists_pkg::CKP_RST;
        end else begin
            st_reg     <= st_next;
            cnt_reg    <= cnt_next;
            shift_reg  <= shift_next;
            buf_reg    <= buf_next;
            sa_reg     <= sa_next;
            sda_oe_reg <= sda_oe_next;
            scl_oe_reg <= scl_oe_next;
            hold_reg   <= hold_next;
            nack_reg   <= nack_next;
            match_reg  <= match_next;
            rw_reg     <= rw_next;
            lo_reg     <= lo_next;
            ten_ok_reg <= ten_ok_next;
            ack_timing_bit_reg <= ack_timing_bit_next;
            ackst_reg  <= ackst_next;
            ss_reg     <= ss_next;
            irq_reg    <= irq_next;
            bf_reg     <= bf_next;
            ua_reg     <= ua_next;
            bcl_reg    <= bcl_next;
            ckp_reg    <= ckp_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs: open drain only
    // ----------------------------------------------------------------
    assign scl_o                  = 1'b0; // RULE_25
    assign sda_o                  = 1'b0; // RULE_25
    assign scl_oe_o               = scl_oe_reg;
    assign sda_oe_o               = sda_oe_reg;
    assign rx_tx_buffer_o         = buf_reg;
    assign slave_address_o        = sa_reg;
    assign buffer_full_flag_o     = bf_reg;
    assign clock_hold_release_o   = ckp_reg;
    assign serial_port_irq_flag_o = irq_reg;
    assign bus_collision_flag_o   = bcl_reg;
    assign start_seen_bit_o       = ss_reg;
    assign ack_status_bit_o       = ackst_reg;
    assign ack_timing_bit_o       = ack_timing_bit_reg;
    assign address_update_flag_o  = ua_reg;
    assign read_write_o           = rw_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    property p_hold_when_low;
        $rose(scl_oe_reg) |-> !$past(scl_s_reg);
    endproperty
    a_hold_when_low: assert property (p_hold_when_low) // RULE_19
        else $error("scl pulled low during its high time");

    property p_release;
        ckp_reg && !ua_reg && !ckp_clr |=> !scl_oe_reg;
    endproperty
    a_release: assert property (p_release) // RULE_04
        else $error("scl still held after release");

    property p_ack_capture;
        scl_rise && cnt_reg == ists_pkg::BIT_LAST && st_reg == ists_pkg::ST_TX && !start_det
            && !stop_det |=> ackst_reg == $past(sda_s_reg);
    endproperty
    a_ack_capture: assert property (p_ack_capture) // RULE_05
        else $error("controller ack not captured on ninth rise");

    property p_tx_irq;
        scl_fall && cnt_reg == ists_pkg::BIT_ACK && st_reg == ists_pkg::ST_TX |=> irq_reg;
    endproperty
    a_tx_irq: assert property (p_tx_irq) // RULE_06
        else $error("no interrupt after read byte ack");

    property p_tx_stretch;
        scl_fall && cnt_reg == ists_pkg::BIT_ACK && st_reg == ists_pkg::ST_TX && !ackst_reg
            |=> !ckp_reg ##1 scl_oe_reg;
    endproperty
    a_tx_stretch: assert property (p_tx_stretch) // RULE_08
        else $error("acked read byte not stretched");

    property p_tx_nack;
        scl_fall && cnt_reg == ists_pkg::BIT_ACK && st_reg == ists_pkg::ST_TX && ackst_reg
            |=> st_reg == ists_pkg::ST_IDLE && !sda_oe_reg;
    endproperty
    a_tx_nack: assert property (p_tx_nack) // RULE_07
        else $error("bus not released after nack");

    property p_collision;
        coll |=> bcl_reg && st_reg == ists_pkg::ST_IDLE && !sda_oe_reg;
    endproperty
    a_collision: assert property (p_collision) // RULE_01
        else $error("collision not flagged or not idle");

    property p_start;
        start_det |=> ss_reg && st_reg == ists_pkg::ST_ADDR && cnt_reg == ists_pkg::CNT_RST;
    endproperty
    a_start: assert property (p_start) // RULE_02
        else $error("start not recorded");

    property p_ua_release;
        address_write_i && !ua_set && ckp_reg |=> !ua_reg ##1 !scl_oe_reg;
    endproperty
    a_ua_release: assert property (p_ua_release) // RULE_14
        else $error("scl not freed after address write");

    property p_buf_full;
        buffer_write_i |=> bf_reg && buf_reg == $past(buffer_wdata_i);
    endproperty
    a_buf_full: assert property (p_buf_full) // RULE_17
        else $error("buffer load did not set full");

    property p_stop;
        stop_det |=> st_reg == ists_pkg::ST_IDLE && !ten_ok_reg;
    endproperty
    a_stop: assert property (p_stop) // RULE_22
        else $error("still addressed after stop");
endmodule

// >>> test/ists_ctrl_model.sv
// i2c bus controller model: pulls clock and data low or releases them
`timescale 1ns/1ps
module ists_ctrl_model (
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_low_o,
    output logic      sda_low_o
);
    initial begin
        scl_low_o = 1'h0;
        sda_low_o = 1'h0;
    end
    // release the clock, then wait out any target stretch, bounded
    task automatic rise();
        int n;
        n = 0;
        scl_low_o = 1'h0;
        while (scl_i !== 1'h1 && n < 4000) begin
            #4;
            n++;
        end
    endtask
    task automatic start();
        sda_low_o = 1'h1;
        #24;
        scl_low_o = 1'h1;
        #20;
    endtask
    // data set mid-low so it never moves while the clock is high
    task automatic xfer(input logic b, output logic r);
        sda_low_o = ~b;
        #8;
        rise();
        #8;
        r = sda_i;
        #12;
        scl_low_o = 1'h1;
        #20;
    endtask
    task automatic stop();
        sda_low_o = 1'h1;
        #8;
        rise();
        #20;
        sda_low_o = 1'h0;
        #24;
    endtask
endmodule

// >>> test/ists_core_bench.sv
// self-checking bench of the i2c target transmit and stretch block
`timescale 1ns/1ps
module ists_core_bench;
    logic       clk = 1'h0;
    logic       rst = 1'h1;
    logic       scl_low, sda_low, s_oe, d_oe, full, clock_hold_release, irq, coll, sseen, astat, atim, rw;
    logic       sirq, hold_en, coll_en, rel, irq_clr, coll_clr, addr_wr, buf_wr, buf_rd;
    logic [1:0] outs;
    logic [7:0] bdata, adata, rbuf, sa;
    logic       ten, stretch_enable, ua;
    int         n_fail = 0;
    int         comparisons = 0;
    int         cyc = 0;
    always #2 clk = ~clk;
    // pull-ups: a released line reads high
    wire scl_w = ~(scl_low | s_oe);
    wire sda_w = ~(sda_low | d_oe);
    ists_ctrl_model m (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(scl_low), .sda_low_o(sda_low));
    ists_core dut (.core_clk_i(clk), .reset_i(rst), .scl_i(scl_w), .sda_i(sda_w),
        .scl_o(outs[1]), .scl_oe_o(s_oe), .sda_o(outs[0]), .sda_oe_o(d_oe),
        .ten_bit_mode_i(ten), .start_irq_enable_i(sirq), .collision_detect_enable_i(coll_en),
        .address_hold_enable_i(hold_en), .data_hold_enable_i(1'h0), .stretch_enable_i(stretch_enable),
        .ack_value_bit_i(1'h0), .clock_hold_release_set_i(rel), .irq_clear_i(irq_clr),
        .collision_clear_i(coll_clr), .address_write_i(addr_wr), .address_wdata_i(adata),
        .buffer_write_i(buf_wr), .buffer_wdata_i(bdata), .buffer_read_i(buf_rd),
        .rx_tx_buffer_o(rbuf), .slave_address_o(sa), .buffer_full_flag_o(full),
        .clock_hold_release_o(clock_hold_release), .serial_port_irq_flag_o(irq), .bus_collision_flag_o(coll),
        .start_seen_bit_o(sseen), .ack_status_bit_o(astat), .ack_timing_bit_o(atim),
        .address_update_flag_o(ua), .read_write_o(rw));
    task automatic finish_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk) s = 1'h1;
        @(negedge clk) s = 1'h0;
    endtask
    task automatic xb(input logic [8:0] tx, input int nb, output logic [8:0] r);
        for (int i = 8; i > 8 - nb; i--) m.xfer(tx[i], r[i]);
    endtask
    task automatic sc_read();
        logic [8:0] r;
        sirq = 1'h1;
        m.start();
        chk({sseen, irq}, 2'h3);
        pulse(irq_clr);
        xb({8'h85, 1'h1}, 9, r);
        chk({r[0], irq, clock_hold_release, rw, s_oe}, 5'hB);
        bdata = 8'hA5;
        pulse(buf_wr);
        chk(full, 1'h1);
        pulse(buf_rd);
        chk(full, 1'h0);
        pulse(buf_wr);
        pulse(irq_clr);
        pulse(rel);
        xb({8'hFF, 1'h0}, 9, r);
        chk(r[8:1], 8'hA5);
        chk({astat, irq, clock_hold_release, full, s_oe}, 5'h9);
        bdata = 8'h3C;
        pulse(buf_wr);
        pulse(irq_clr);
        pulse(rel);
        xb({8'hFF, 1'h1}, 9, r);
        chk(r[8:1], 8'h3C);
        chk({astat, irq, s_oe, outs}, 5'h18);
        m.stop();
        $display("sc_read done");
    endtask
    task automatic sc_hold();
        logic [8:0] r;
        hold_en = 1'h1;
        coll_en = 1'h1;
        m.start();
        pulse(irq_clr);
        xb({8'h85, 1'h1}, 8, r);
        chk({irq, clock_hold_release, atim, s_oe}, 4'hB);
        pulse(irq_clr);
        pulse(rel);
        m.xfer(1'h1, r[0]);
        chk({r[0], irq, clock_hold_release}, 3'h2);
        bdata = 8'hFF;
        pulse(buf_wr);
        pulse(rel);
        m.xfer(1'h0, r[8]);
        chk({coll, s_oe}, 2'h2);
        m.stop();
        pulse(coll_clr);
        chk(coll, 1'h0);
        $display("sc_hold done");
    endtask
    // 10-bit write: matching low byte then data with stretch, second pass a wrong low byte
    task automatic sc_ten();
        logic [8:0] r;
        {ten, stretch_enable, hold_en, adata} = {3'h6, 8'h02};
        pulse(addr_wr);
        for (int k = 0; k < 2; k++) begin
            m.start();
            pulse(irq_clr);
            xb({8'hF2, 1'h1}, 9, r);
            chk({r[0], irq, ua, clock_hold_release, s_oe}, 5'h0F);
            chk(rbuf, 8'hF2);
            pulse(buf_rd);
            pulse(irq_clr);
            adata = 8'h5A;
            pulse(addr_wr);
            chk(sa, 8'h5A);
            xb({8'h5A + k[7:0], 1'h1}, 9, r);
            chk({r[0], irq, ua, full, clock_hold_release}, k ? 5'h1D : 5'h0F);
            adata = 8'h02;
            pulse(addr_wr);
            xb({8'h33, 1'h1}, 9, r);
            chk({r[0], clock_hold_release, s_oe}, k ? 3'h6 : 3'h1);
            chk(rbuf, k ? 8'hF2 : 8'h33);
            pulse(rel);
            m.stop();
        end
        {ten, stretch_enable} = 2'h0;
        $display("sc_ten done");
    endtask
    initial begin
        {sirq, hold_en, coll_en, rel, irq_clr, coll_clr, addr_wr, buf_wr, buf_rd} = '0;
        {ten, stretch_enable} = 2'h0;
        bdata = 8'h00;
        adata = 8'h84;
        repeat (12) @(posedge clk);
        @(negedge clk) rst = 1'h0;
        repeat (4) @(negedge clk);
        pulse(addr_wr);
        sc_read();
        sc_hold();
        sc_ten();
        finish_test();
    end
endmodule
